// [inc/gsr_defs.svh]
// constants of the gyro start-up and reset sequencer
`ifndef GSR_DEFS_SVH
`define GSR_DEFS_SVH
`define GSR_ADDR_RATE      7'h00
`define GSR_ADDR_ID        7'h07
`define GSR_ADDR_STATUS    7'h08
`define GSR_RESET_CODE     15'h0004
`define GSR_WORD_BITS      5'h10
`define GSR_LAST_BIT       5'h0f
`define GSR_BIT_RW         2
`define GSR_BIT_ZERO       1
`define GSR_BIT_PAR        0
`define GSR_ADR_LSB        3
`define GSR_ADR_MSB        9
`define GSR_TOP_LSB        10
`define GSR_STARTUP_FLAGS  15'h0001
`define GSR_RST_HOLD       4'h3
`endif

// [inc/gsr_pkg.sv]
// types of the gyro start-up and reset sequencer
package gsr_pkg;
  typedef enum logic [1:0] {GSR_ADDR, GSR_DATA, GSR_DUMMY} gsr_phase_t;
  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic        par_ok;
  } gsr_cmd_t;
endpackage : gsr_pkg

// [hw/gsr_spi_shift.sv]
// spi word shifter: collects 16 mosi bits and shifts out a 16-bit answer
`timescale 1ns/1ps
`include "gsr_defs.svh"
module gsr_spi_shift #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             cs_active,
  input  wire logic             sck_rise,
  input  wire logic             sck_fall,
  input  wire logic             mosi,
  input  wire logic [WIDTH-1:0] tx_word,
  output logic                  miso,
  output logic [WIDTH-1:0]      rx_word,
  output logic                  rx_done
);
  logic [WIDTH-1:0] rx_sh_q;
  logic [WIDTH-1:0] tx_sh_q;
  logic [4:0]       cnt_q;
  logic             first_q;

  // refused at elaboration: the bit counter and frame format assume 16-bit words
  if (WIDTH != 16) begin : g_width_check
    $error("gsr_spi_shift supports 16-bit words only");
  end

  // ------------------------------------------------------------
  // receive on rising sck, word complete after 16 bits
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || !cs_active) begin
      rx_sh_q <= '0;
      cnt_q   <= '0;
      rx_done <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_done <= 1'b0;
      if (sck_rise) begin
        rx_sh_q <= {rx_sh_q[WIDTH-2:0], mosi};
        if (cnt_q == `GSR_LAST_BIT) begin
          cnt_q   <= '0;
          rx_done <= 1'b1;
          rx_word <= {rx_sh_q[WIDTH-2:0], mosi};
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // transmit: msb presented at select, next bit on falling sck
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || !cs_active) begin
      tx_sh_q <= '0;
      miso    <= 1'b0;
      first_q <= 1'b1;
    end else if (first_q || (sck_fall && cnt_q == '0)) begin
      tx_sh_q <= {tx_word[WIDTH-2:0], 1'b0};
      miso    <= tx_word[WIDTH-1];
      first_q <= 1'b0;
    end else if (sck_fall) begin
      tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
      miso    <= tx_sh_q[WIDTH-1];
    end
  end
endmodule : gsr_spi_shift

// [hw/gsr_sequencer.sv]
// gyro start-up and reset sequencer behind a 4-wire spi slave port
`timescale 1ns/1ps
`include "gsr_defs.svh"

// Functional notes
// - rate data is readable right after reset with no start-up command needed.
// - the device clears its start-up error flags after the second status read following power-up.
// - a write of 0x04 to the identification register at 07h resets the device.
// - the device is held in reset while the external reset input is low and leaves it when high.
// - the first word after select falls is an address word with address, write bit and odd parity.
module gsr_sequencer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        external_reset_low_input,
  input  wire logic        sensor_chip_select_low,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  input  wire logic [14:0] rate_value,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic             core_reset_q
);
  logic                 sck_q;
  logic                 cs_active;
  logic                 rx_done;
  logic [15:0]          rx_word;
  logic [15:0]          tx_word_q;
  logic                 miso_raw;
  logic                 soft_rst_q;
  logic [3:0]           hold_q;
  logic [14:0]          flags_q;
  logic [14:0]          id_q;
  logic [1:0]           status_reads_q;
  gsr_pkg::gsr_phase_t  phase_q;
  gsr_pkg::gsr_cmd_t    cmd_q;
  logic                 dev_rst;
  logic                 sck_rise;
  logic                 sck_fall;
  logic                 addr_par_ok;
  logic                 data_par_ok;
  logic                 status_ok;
  logic [14:0]          answer_val;

  assign cs_active   = !sensor_chip_select_low;
  assign status_ok   = (flags_q == '0); // s_ok bit: no start-up flag left
  assign sck_rise    = spi_sck && !sck_q;
  assign sck_fall    = !spi_sck && sck_q;
  assign dev_rst     = rst || !external_reset_low_input || soft_rst_q;
  assign addr_par_ok = ^rx_word; // odd number of ones over all 16 bits
  assign data_par_ok = ^rx_word;

  // ------------------------------------------------------------
  // spi edge detection and word shifter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= spi_sck;
    end
  end

  gsr_spi_shift #(.WIDTH(16)) u_shift (
    .core_clk  (core_clk),
    .rst       (dev_rst),
    .cs_active (cs_active),
    .sck_rise  (sck_rise),
    .sck_fall  (sck_fall),
    .mosi      (spi_mosi),
    .tx_word   (tx_word_q),
    .miso      (miso_raw),
    .rx_word   (rx_word),
    .rx_done   (rx_done)
  );

  // ------------------------------------------------------------
  // pin drivers: miso driven only while selected
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= miso_raw;
      spi_miso_oe <= cs_active;
    end
  end

  // ------------------------------------------------------------
  // reset stretch: a soft reset lasts a few cycles so the whole core sees it
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || !external_reset_low_input) begin
      soft_rst_q   <= 1'b0;
      hold_q       <= '0;
      core_reset_q <= 1'b1;
    end else if (soft_rst_q) begin
      core_reset_q <= 1'b1;
      if (hold_q == `GSR_RST_HOLD) begin
        soft_rst_q <= 1'b0;
        hold_q     <= '0;
      end else begin
        hold_q <= hold_q + 4'h1;
      end
    end else begin
      core_reset_q <= 1'b0;
      // reset code accepted only on a clean-parity write to the id register
      if (rx_done && phase_q == gsr_pkg::GSR_DATA && cmd_q.wr && cmd_q.par_ok && data_par_ok
          && cmd_q.addr == `GSR_ADDR_ID && rx_word[15:1] == `GSR_RESET_CODE) begin
        soft_rst_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // frame decode: address word first after select, data word after a write
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (dev_rst || sensor_chip_select_low) begin
      phase_q <= gsr_pkg::GSR_ADDR;
      cmd_q   <= '0;
    end else if (rx_done) begin
      if (phase_q == gsr_pkg::GSR_ADDR || phase_q == gsr_pkg::GSR_DUMMY) begin
        cmd_q.addr   <= rx_word[`GSR_ADR_MSB:`GSR_ADR_LSB];
        cmd_q.wr     <= rx_word[`GSR_BIT_RW];
        cmd_q.par_ok <= addr_par_ok && rx_word[15:`GSR_TOP_LSB] == 6'h00 && !rx_word[`GSR_BIT_ZERO];
        phase_q      <= rx_word[`GSR_BIT_RW] ? gsr_pkg::GSR_DATA : gsr_pkg::GSR_ADDR;
      end else begin
        phase_q <= gsr_pkg::GSR_ADDR;
        cmd_q   <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // answer word: register value after an address word, status flags after a data word
  // ------------------------------------------------------------
  // value for the next word, decoded from the word just completed
  always_comb begin
    answer_val = '0;
    if (phase_q == gsr_pkg::GSR_DATA) begin
      answer_val = {14'h0000, status_ok}; // status flags follow every data word
    end else begin
      unique case (rx_word[`GSR_ADR_MSB:`GSR_ADR_LSB])
        `GSR_ADDR_RATE:   answer_val = rate_value; // rate readable at once
        `GSR_ADDR_ID:     answer_val = id_q;
        `GSR_ADDR_STATUS: answer_val = flags_q;
        default:          answer_val = '0; // unmapped addresses answer zero
      endcase
    end
  end

  // latched on the word boundary so the shifter reloads a stable value
  always_ff @(posedge core_clk) begin
    if (dev_rst || sensor_chip_select_low) begin
      tx_word_q <= {14'h0000, status_ok, !status_ok}; // frame opens with the status flags
    end else if (rx_done) begin
      tx_word_q <= {answer_val, ~^answer_val};
    end
  end

  // ------------------------------------------------------------
  // start-up flags: set at reset, cleared by the second status read
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      flags_q        <= `GSR_STARTUP_FLAGS;
      status_reads_q <= '0;
    end else if (rx_done && phase_q != gsr_pkg::GSR_DATA && !rx_word[`GSR_BIT_RW]
                 && rx_word[`GSR_ADR_MSB:`GSR_ADR_LSB] == `GSR_ADDR_STATUS && status_reads_q != 2'h2) begin
      status_reads_q <= status_reads_q + 2'h1;
      if (status_reads_q == 2'h1) begin
        flags_q <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // identification register holds last accepted non-reset write
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      id_q <= '0;
    end else if (rx_done && phase_q == gsr_pkg::GSR_DATA && cmd_q.wr && cmd_q.par_ok && data_par_ok
                 && cmd_q.addr == `GSR_ADDR_ID && rx_word[15:1] != `GSR_RESET_CODE) begin
      id_q <= rx_word[15:1];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // pin released and no soft reset pending, two edges in a row
  sequence s_pin_released;
    external_reset_low_input && !soft_rst_q;
  endsequence

  sequence s_core_free;
    s_pin_released ##1 s_pin_released;
  endsequence

  a_ext_reset_holds: assert property (@(posedge core_clk) disable iff (rst)
    !external_reset_low_input |=> core_reset_q) else $error("core not held in reset");
  a_ext_reset_leaves: assert property (@(posedge core_clk) disable iff (rst)
    s_core_free |=> !core_reset_q) else $error("core stuck in reset");
  a_flags_after_reset: assert property (@(posedge core_clk) disable iff (rst)
    !external_reset_low_input |=> flags_q == `GSR_STARTUP_FLAGS) else $error("flags not set at reset");
  a_soft_reset_pulse: assert property (@(posedge core_clk) disable iff (rst)
    $rose(soft_rst_q) && external_reset_low_input |=> core_reset_q) else $error("soft reset missed");
  a_status_clear: assert property (@(posedge core_clk) disable iff (rst || dev_rst)
    $fell(flags_q != '0) |-> status_reads_q == 2'h2) else $error("flags cleared early");
  a_first_word_addr: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sensor_chip_select_low) |=> phase_q == gsr_pkg::GSR_ADDR) else $error("frame not at address");
  a_miso_oe_select: assert property (@(posedge core_clk) disable iff (rst)
    sensor_chip_select_low |=> !spi_miso_oe) else $error("miso driven while idle");
  a_reset_bounded: assert property (@(posedge core_clk) disable iff (rst || !external_reset_low_input)
    $rose(soft_rst_q) |-> ##[1:6] !soft_rst_q) else $error("soft reset too long");
  a_rate_answer: assert property (@(posedge core_clk) disable iff (dev_rst)
    rx_done && phase_q != gsr_pkg::GSR_DATA && rx_word[`GSR_ADR_MSB:`GSR_ADR_LSB] == `GSR_ADDR_RATE
    |=> sensor_chip_select_low || tx_word_q[15:1] == $past(rate_value)) else $error("rate not answered");
  a_soft_reset_cause: assert property (@(posedge core_clk) disable iff (rst || !external_reset_low_input)
    $rose(soft_rst_q) |-> $past(rx_done)) else $error("soft reset without a word");
endmodule : gsr_sequencer

// [verif/gsr_host_model.sv]
// host spi master model that drives the sensor port word by word
`timescale 1ns/1ps
module gsr_host_model (
  input  wire logic core_clk,
  output logic      spi_sck,
  output logic      spi_mosi,
  output logic      sensor_chip_select_low,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  logic miso_last;
  logic miso_w;

  // a released miso floats: show the inverse of the last driven bit
  assign miso_w = spi_miso_oe ? spi_miso : ~miso_last;
  always_ff @(posedge core_clk) if (spi_miso_oe) miso_last <= spi_miso;

  // idle: select high, clock parked low between frames
  task automatic idle();
    spi_sck <= 1'b0;
    spi_mosi <= 1'b0;
    sensor_chip_select_low <= 1'b1;
  endtask : idle

  // odd parity over the whole word
  function automatic logic [15:0] seal(input logic [14:0] v);
    return {v, ~^v};
  endfunction : seal

  // address word: six zero bits, address, write bit, zero bit, parity
  function automatic logic [15:0] adr(input logic [6:0] a, input logic rw);
    return seal({6'h00, a, rw, 1'b0});
  endfunction : adr

  task automatic open_frame();
    @(posedge core_clk) sensor_chip_select_low <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : open_frame

  // msb first; sck half period of four core cycles keeps it below core/4
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      @(posedge core_clk) begin
        spi_sck <= 1'b0;
        spi_mosi <= tx[i];
      end
      repeat (3) @(posedge core_clk);
      @(posedge core_clk) begin
        rx[i] = miso_w;
        spi_sck <= 1'b1;
      end
      repeat (3) @(posedge core_clk);
    end
  endtask : word

  task automatic close_frame();
    @(posedge core_clk) spi_sck <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(posedge core_clk) sensor_chip_select_low <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : close_frame
endmodule : gsr_host_model

// [verif/testbench.sv]
// self-checking bench for the gyro start-up and reset sequencer
`timescale 1ns/1ps
module testbench;
  logic        core_clk;
  logic        rst;
  logic        ext_rst_n;
  logic [14:0] rate_value;
  logic        sck, mosi, cs_n, miso, miso_oe, core_reset_q;
  logic [7:0]  n_core_rst;
  logic [15:0] r0, r1, r2, r3, r4;
  int          n_mismatch = 0;
  int          check_count = 0;

  gsr_sequencer gsr_sequencer_inst (
    .core_clk(core_clk), .rst(rst), .external_reset_low_input(ext_rst_n),
    .sensor_chip_select_low(cs_n), .spi_sck(sck), .spi_mosi(mosi), .rate_value(rate_value),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .core_reset_q(core_reset_q));
  gsr_host_model gsr_host_model_inst (
    .core_clk(core_clk), .spi_sck(sck), .spi_mosi(mosi), .sensor_chip_select_low(cs_n),
    .spi_miso(miso), .spi_miso_oe(miso_oe));

  // 100 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // counts cycles the core spends in reset; scenarios compare before and after
  always @(posedge core_clk) begin
    if (rst) n_core_rst <= 8'h00;
    else if (core_reset_q === 1'b1) n_core_rst <= n_core_rst + 8'h01;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // pin low holds the core; release lets it run within a few edges
  task automatic t_pin_reset();
    @(posedge core_clk) ext_rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check("reset held", {15'h0000, core_reset_q}, 16'h0001);
    @(posedge core_clk) ext_rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("reset left", {15'h0000, core_reset_q}, 16'h0000);
  endtask : t_pin_reset

  // two status reads clear the start-up flag, a third shows it gone; rate needs no set-up
  task automatic t_status();
    gsr_host_model_inst.open_frame();
    check("miso enable", {15'h0000, miso_oe}, 16'h0001);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h08, 1'b0), r0);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h08, 1'b0), r1);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h08, 1'b0), r2);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h00, 1'b0), r3);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h00, 1'b0), r4);
    gsr_host_model_inst.close_frame();
    check("miso release", {15'h0000, miso_oe}, 16'h0000);
    check("status flags s_ok low", r0, gsr_host_model_inst.seal(15'h0000));
    check("status first", r1, gsr_host_model_inst.seal(15'h0001));
    check("status third", r3, gsr_host_model_inst.seal(15'h0000));
    check("rate", r4, gsr_host_model_inst.seal(rate_value));
  endtask : t_status

  // soft reset write: bad parity is dropped, a good one resets
  task automatic soft_write(input logic [15:0] aw);
    gsr_host_model_inst.open_frame();
    gsr_host_model_inst.word(aw, r0);
    gsr_host_model_inst.word(gsr_host_model_inst.seal(15'h0004), r1);
    gsr_host_model_inst.close_frame();
    repeat (10) @(posedge core_clk);
  endtask : soft_write

  task automatic t_soft_reset();
    logic [7:0] base;
    base = n_core_rst;
    soft_write(gsr_host_model_inst.adr(7'h07, 1'b1) ^ 16'h0001);
    check("bad parity write", {15'h0000, n_core_rst != base}, 16'h0000);
    soft_write(gsr_host_model_inst.adr(7'h07, 1'b1));
    check("soft reset", {15'h0000, n_core_rst != base}, 16'h0001);
    gsr_host_model_inst.open_frame();
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h08, 1'b0), r0);
    gsr_host_model_inst.word(gsr_host_model_inst.adr(7'h00, 1'b0), r1);
    gsr_host_model_inst.close_frame();
    check("s_ok after reset", r0, gsr_host_model_inst.seal(15'h0000));
    check("flag after reset", r1, gsr_host_model_inst.seal(15'h0001));
  endtask : t_soft_reset

  // main sequence; pin stays low through the supply ramp
  initial begin
    rst = 1'b1;
    ext_rst_n = 1'b0;
    rate_value = 15'h2a5c;
    gsr_host_model_inst.idle();
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_pin_reset();
    repeat (20) @(posedge core_clk); // shortened settle wait
    t_status();
    t_soft_reset();
    t_pin_reset(); // second pin release in mid-run sets the start-up flag again
    t_status();
    give_verdict();
  end

  // a hang is cut short well past the expected run of some 2200 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
